//--- inc/flp_pkg.sv
/*
 * Shared constants and carriers for the flash row program and protect sequencer.
 * Assumes a 50 MHz bus clock and a 16-bit flash address space that ends at the top address.
 */
package flp_pkg;

    // ------------------------------------------------------------------
    // register map, byte addresses on the bus
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL    = 8'h00;  // select and high voltage bits
    localparam logic [7:0] OFS_PROTECT = 8'h04;  // protect byte mirror, read only
    localparam logic [7:0] OFS_STATUS  = 8'h08;  // sequence state and sticky refusals
    localparam logic [7:0] OFS_LATCH   = 8'h0C;  // latched address and data

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CTRL_PGM_BIT   = 0;
    localparam int CTRL_ERASE_BIT = 1;
    localparam int CTRL_MASS_BIT  = 2;
    localparam int CTRL_HV_BIT    = 3;
    localparam int STAT_HVREF_BIT = 4;  // high voltage request refused
    localparam int STAT_WRIGN_BIT = 5;  // flash write ignored
    localparam int STAT_RDY_BIT   = 6;  // array readable
    localparam int STAT_PROT_BIT  = 7;  // latched address lies in protected range

    // ------------------------------------------------------------------
    // reset values and address layout
    // ------------------------------------------------------------------
    localparam logic [3:0]  CTRL_RESET      = 4'h0;
    localparam logic [7:0]  PROTECT_ALL_ONE = 8'hFF;
    localparam logic [1:0]  START_TOP_BITS  = 2'h3;   // address bits 15..14
    localparam logic [5:0]  START_LOW_BITS  = 6'h00;  // address bits 5..0
    localparam logic [15:0] PROTECT_ADDR    = 16'hFFBE;
    localparam int          ROW_LSB         = 5;      // 32-byte rows

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int SELECT_TO_HV_DELAY_NS      = 10000;  // select to high voltage delay
    localparam int HV_TO_WRITE_DELAY_NS      = 5000;   // high voltage to write delay
    localparam int BYTE_WRITE_TIME_NS     = 30000;  // byte write time
    localparam int DESELECT_TO_HV_OFF_DELAY_NS      = 5000;   // deselect to high voltage off delay
    localparam int READ_RECOVERY_TIME_NS      = 1000;   // read recovery time
    localparam int CYC_NVS  = (SELECT_TO_HV_DELAY_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_PGS  = (HV_TO_WRITE_DELAY_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_PROG = (BYTE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_NVH  = (DESELECT_TO_HV_OFF_DELAY_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYC_BCV  = (READ_RECOVERY_TIME_NS  + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W    = 11;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SELECTED,
        ST_CHECKED,
        ST_LATCHED,
        ST_HV,
        ST_HOLD,
        ST_RECOVER
    } flp_state_e;

    typedef struct packed {
        logic        wr;    // one-cycle cpu write into a flash location
        logic [15:0] addr;
        logic [7:0]  data;
    } flp_mem_wr_s;

    typedef struct packed {
        logic        program_select;       // array configured for program
        logic        erase;     // array configured for erase
        logic        mass;      // mass erase selected
        logic        hv;        // charge pump and high voltage on
        logic        prog_stb;  // one-cycle pulse: program data at addr
        logic [15:0] addr;
        logic [7:0]  data;
    } flp_array_s;

endpackage

//--- hw/flp_protect_chk.sv
/*
 * Protect range check: builds the protect start address and flags a protected target.
 * Assumes the protect byte value is read straight from the array.
 */
`timescale 1ns/1ps
module flp_protect_chk (
    input  wire logic [7:0]  protect_byte_i,  // block protect byte from the array
    input  wire logic [15:0] addr_i,          // address under test
    input  wire logic        test_hv_i,       // test high voltage present on irq pin
    output logic      [15:0] start_o,         // first protected address
    output logic             protected_o      // addr_i may not be programmed or erased
);
    // ------------------------------------------------------------------
    // start address and range compare
    // ------------------------------------------------------------------
    wire logic all_open  = (protect_byte_i == flp_pkg::PROTECT_ALL_ONE);
    wire logic in_range  = (addr_i >= start_o);
    wire logic self_addr = (addr_i == flp_pkg::PROTECT_ADDR);

    // byte to bits 13..6, top two ones, low six zeros
    assign start_o = {flp_pkg::START_TOP_BITS, protect_byte_i, flp_pkg::START_LOW_BITS};
    // low values start below the array so all is covered, 0xFE covers the top region
    // the protect byte itself opens only under test high voltage
    assign protected_o = self_addr ? !test_hv_i : (!all_open && in_range);
endmodule

//--- hw/flp_row_prog.sv
/*
 * Flash row program sequencer with block protection, as a classic Wishbone slave.
 * Assumes cpu flash writes arrive as one-cycle strobes, and that the protect byte
 * and the test high voltage level are supplied by the array and pad logic.
 *
// Summary of operation
// - Programming works one 32-byte aligned row at a time.
// - Program-select configures programming and enables address and data latching.
// - Clear select, wait 5 us, clear high voltage, then 1 us read recovery.
// - High voltage refused when the target lies in the protected range.
// - Protect byte zero protects everything; all ones protects nothing.
// - Any protection blocks the protect byte, protected region and mass erase.
// - Protect byte changes only under test high voltage on the irq pin.
// - Protect start address is 11, protect byte, then six zeros.
// - Low protect values below array start protect the whole array.
// - Value 0xFE protects the top 128-byte region and vectors.
// - Protect byte is changed only by flash programming, never a bus write.
// - Wait or stop during an operation aborts it to standby.
// - Standby drives all flash controls inactive; read mode ignores low power.
// - High voltage settable only with a select bit and correct sequence.
// - Program-select and erase-select never both one.
 */
`timescale 1ns/1ps
module flp_row_prog #(
    parameter int CNT_W = flp_pkg::CNT_W  // width of the delay counter
) (
    input  wire logic               clk_i,           // 50 MHz bus clock
    input  wire logic               rst_i,           // synchronous reset, active high
    input  wire logic               cyc_i,           // wishbone cycle
    input  wire logic               stb_i,           // wishbone strobe
    input  wire logic               we_i,            // wishbone write enable
    input  wire logic [7:0]         adr_i,           // wishbone byte address
    input  wire logic [3:0]         sel_i,           // wishbone byte selects
    input  wire logic [31:0]        dat_i,           // wishbone write data
    output logic      [31:0]        dat_o,           // wishbone read data
    output logic                    ack_o,           // wishbone acknowledge
    input  flp_pkg::flp_mem_wr_s    mem_wr_i,        // cpu write into flash space
    input  wire logic [7:0]         protect_byte_i,  // protect byte held in the array
    input  wire logic               test_hv_i,       // test high voltage on irq pin
    input  wire logic               low_power_i,     // wait or stop entered
    output flp_pkg::flp_array_s     array_o,         // controls to the flash array
    output logic                    read_ready_o     // array readable
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    flp_pkg::flp_state_e state;
    flp_pkg::flp_state_e next_state;
    logic             program_select;
    logic             erase;
    logic             mass;
    logic             hv;
    logic             hv_refused;
    logic             wr_ignored;
    logic [15:0]      latch_addr;
    logic [7:0]       latch_data;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;
    logic             prog_stb;
    logic             ack;
    logic [31:0]      rdata;

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire logic req      = cyc_i && stb_i && !ack;
    wire logic wr_lane  = sel_i[0];
    wire logic hit_ctrl = (adr_i == flp_pkg::OFS_CTRL);
    wire logic hit_prot = (adr_i == flp_pkg::OFS_PROTECT);
    wire logic hit_stat = (adr_i == flp_pkg::OFS_STATUS);
    wire logic hit_lat  = (adr_i == flp_pkg::OFS_LATCH);
    wire logic ctrl_wr  = req && we_i && wr_lane && hit_ctrl;
    wire logic stat_wr  = req && we_i && wr_lane && hit_stat;
    wire logic prot_rd  = req && !we_i && hit_prot;

    wire logic w_pgm    = dat_i[flp_pkg::CTRL_PGM_BIT];
    wire logic w_erase  = dat_i[flp_pkg::CTRL_ERASE_BIT];
    wire logic w_mass   = dat_i[flp_pkg::CTRL_MASS_BIT];
    wire logic w_hv     = dat_i[flp_pkg::CTRL_HV_BIT];
    wire logic timer_ok = (cnt == '0);

    // ------------------------------------------------------------------
    // protect check on the latched and incoming addresses
    // ------------------------------------------------------------------
    logic tgt_prot;
    logic in_prot;

    flp_protect_chk u_chk_latch (
        .protect_byte_i (protect_byte_i),
        .addr_i         (latch_addr),
        .test_hv_i      (test_hv_i),
        .start_o        (),
        .protected_o    (tgt_prot)
    );

    flp_protect_chk u_chk_wr (
        .protect_byte_i (protect_byte_i),
        .addr_i         (mem_wr_i.addr),
        .test_hv_i      (test_hv_i),
        .start_o        (),
        .protected_o    (in_prot)
    );

    // ------------------------------------------------------------------
    // sequence decisions
    // ------------------------------------------------------------------
    wire logic active    = (state != flp_pkg::ST_IDLE) && (state != flp_pkg::ST_RECOVER);
    wire logic abort     = low_power_i && active;
    // select is taken only from idle and never together with the other select
    wire logic sel_pgm   = ctrl_wr && w_pgm && !w_erase && !erase && (state == flp_pkg::ST_IDLE);
    wire logic sel_erase = ctrl_wr && w_erase && !w_pgm && !program_select && (state == flp_pkg::ST_IDLE);
    wire logic mass_ok   = !w_mass || (protect_byte_i == flp_pkg::PROTECT_ALL_ONE);
    // high voltage needs a select, a latched target past its delay, and no protection
    wire logic hv_set    = ctrl_wr && w_hv && !hv && (program_select || erase)
                           && (state == flp_pkg::ST_LATCHED) && timer_ok && !tgt_prot && !(mass && !mass_ok);
    wire logic hv_req_bad = ctrl_wr && w_hv && !hv && !hv_set;
    // high voltage may drop only after deselect and its hold time
    wire logic hv_clr    = ctrl_wr && !w_hv && hv && (state == flp_pkg::ST_HOLD) && timer_ok;
    // the latching write must follow the protect read
    wire logic latch_wr  = mem_wr_i.wr && (state == flp_pkg::ST_CHECKED);
    // a program write stays in the latched row, after the timers, outside protection
    wire logic same_row  = (mem_wr_i.addr[15:flp_pkg::ROW_LSB] == latch_addr[15:flp_pkg::ROW_LSB]);
    wire logic prog_wr   = mem_wr_i.wr && program_select && hv && (state == flp_pkg::ST_HV)
                           && timer_ok && same_row && !in_prot;
    // any other write during a sequence is dropped; plain writes never alter the array
    wire logic wr_bad    = mem_wr_i.wr && active && !latch_wr && !prog_wr;
    // deselect loses to a program write in the same cycle
    wire logic desel     = ctrl_wr && !w_pgm && !w_erase && (program_select || erase) && !prog_wr;

    // ------------------------------------------------------------------
    // next state and delay counter
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_cnt   = timer_ok ? cnt : cnt - CNT_W'(1);
        case (state)
            flp_pkg::ST_IDLE: begin
                if (sel_pgm || sel_erase) begin
                    next_state = flp_pkg::ST_SELECTED;
                end
            end
            flp_pkg::ST_SELECTED: begin
                if (prot_rd) begin
                    next_state = flp_pkg::ST_CHECKED;
                end
            end
            flp_pkg::ST_CHECKED: begin
                if (latch_wr) begin
                    next_state = flp_pkg::ST_LATCHED;
                    next_cnt   = CNT_W'(flp_pkg::CYC_NVS);
                end
            end
            flp_pkg::ST_LATCHED: begin
                if (hv_set) begin
                    next_state = flp_pkg::ST_HV;
                    next_cnt   = CNT_W'(flp_pkg::CYC_PGS);
                end
            end
            flp_pkg::ST_HV: begin
                if (prog_wr) begin
                    next_cnt = CNT_W'(flp_pkg::CYC_PROG);
                end else if (desel) begin
                    next_state = flp_pkg::ST_HOLD;
                    next_cnt   = CNT_W'(flp_pkg::CYC_NVH);
                end
            end
            flp_pkg::ST_HOLD: begin
                if (hv_clr) begin
                    next_state = flp_pkg::ST_RECOVER;
                    next_cnt   = CNT_W'(flp_pkg::CYC_BCV);
                end
            end
            flp_pkg::ST_RECOVER: begin
                if (timer_ok) begin
                    next_state = flp_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = flp_pkg::ST_IDLE;
            end
        endcase
        // deselect before high voltage falls back to idle without recovery
        if (desel && state != flp_pkg::ST_HV && state != flp_pkg::ST_HOLD) begin
            next_state = flp_pkg::ST_IDLE;
        end
        if (abort) begin
            next_state = flp_pkg::ST_IDLE;
            next_cnt   = '0;
        end
    end

    // sequence registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= flp_pkg::ST_IDLE;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // ------------------------------------------------------------------
    // control bits; standby clears them all
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i || abort || next_state == flp_pkg::ST_IDLE) begin
            program_select   <= flp_pkg::CTRL_RESET[flp_pkg::CTRL_PGM_BIT];
            erase <= flp_pkg::CTRL_RESET[flp_pkg::CTRL_ERASE_BIT];
            mass  <= flp_pkg::CTRL_RESET[flp_pkg::CTRL_MASS_BIT];
            hv    <= flp_pkg::CTRL_RESET[flp_pkg::CTRL_HV_BIT];
        end else begin
            if (sel_pgm) begin
                program_select <= 1'b1;
            end
            if (sel_erase) begin
                erase <= 1'b1;
                mass  <= w_mass && mass_ok;
            end
            if (desel) begin
                program_select   <= 1'b0;
                erase <= 1'b0;
                mass  <= 1'b0;
            end
            if (hv_set) begin
                hv <= 1'b1;
            end else if (hv_clr) begin
                hv <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // address and data latch, program strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            latch_addr <= '0;
            latch_data <= '0;
            prog_stb   <= 1'b0;
        end else begin
            prog_stb <= prog_wr && !abort;
            if (latch_wr || prog_wr) begin
                latch_addr <= mem_wr_i.addr;
                latch_data <= mem_wr_i.data;
            end
        end
    end

    // ------------------------------------------------------------------
    // sticky refusals: hardware set wins over software clear
    // ------------------------------------------------------------------
    wire logic clr_hvref = stat_wr && dat_i[flp_pkg::STAT_HVREF_BIT];
    wire logic clr_wrign = stat_wr && dat_i[flp_pkg::STAT_WRIGN_BIT];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hv_refused <= 1'b0;
            wr_ignored <= 1'b0;
        end else begin
            hv_refused <= hv_req_bad || (hv_refused && !clr_hvref);
            wr_ignored <= wr_bad || (wr_ignored && !clr_wrign);
        end
    end

    // ------------------------------------------------------------------
    // read mux and acknowledge
    // ------------------------------------------------------------------
    wire logic [3:0]  ctrl_val = {hv, mass, erase, program_select};
    wire logic [7:0]  stat_val = {tgt_prot, read_ready_o, wr_ignored, hv_refused, 1'b0, state};
    // protect byte is read only on the bus
    assign rdata = hit_ctrl ? {28'h0000000, ctrl_val} :
                   hit_prot ? {24'h000000, protect_byte_i} :
                   hit_stat ? {24'h000000, stat_val} :
                   hit_lat  ? {8'h00, latch_data, latch_addr} :
                   32'h00000000;

    // single-wait-state answer, unmapped reads as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack   <= 1'b0;
            dat_o <= '0;
        end else begin
            ack <= req;
            if (req && !we_i) begin
                dat_o <= rdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign ack_o            = ack;
    assign read_ready_o     = (state == flp_pkg::ST_IDLE) || (state == flp_pkg::ST_SELECTED)
                              || (state == flp_pkg::ST_CHECKED);
    assign array_o.program_select      = program_select;
    assign array_o.erase    = erase;
    assign array_o.mass     = mass;
    assign array_o.hv       = hv;
    assign array_o.prog_stb = prog_stb;
    assign array_o.addr     = latch_addr;
    assign array_o.data     = latch_data;
endmodule

//--- tb/flp_row_prog_sva.sv
/* checker for flp_row_prog: bus answer, select interlock, protection, abort to standby
   assumes it is bound to flp_row_prog and sees only its ports */
`timescale 1ns/1ps
module flp_row_prog_sva #(
    parameter int CNT_W = flp_pkg::CNT_W  // delay counter width
) (
    input wire logic          clk_i,           // bus clock
    input wire logic          rst_i,           // sync reset
    input wire logic          cyc_i,           // bus cycle
    input wire logic          stb_i,           // bus strobe
    input wire logic          ack_o,           // bus answer
    input wire logic [7:0]    protect_byte_i,  // protect byte
    input wire logic          test_hv_i,       // test high voltage
    input wire logic          low_power_i,     // wait or stop
    input flp_pkg::flp_array_s array_o,        // array controls
    input wire logic          read_ready_o     // array readable
);
    // ------------------------------------------------------------------
    // protect start and properties
    // ------------------------------------------------------------------
    wire [15:0] start = {flp_pkg::START_TOP_BITS, protect_byte_i, flp_pkg::START_LOW_BITS};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_hv_on;
        $rose(array_o.hv);
    endsequence
    a_ack_answer: assert property (s_req |=> ack_o) else $error("no ack after request");
    a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
    a_sel_excl: assert property (!(array_o.program_select && array_o.erase)) else $error("both selects");
    a_hv_with_sel: assert property (s_hv_on |-> array_o.program_select || array_o.erase)
        else $error("high voltage without select");
    a_hv_unprot: assert property (s_hv_on |-> protect_byte_i == 8'hFF || array_o.addr < start
        || (test_hv_i && array_o.addr == flp_pkg::PROTECT_ADDR)) else $error("high voltage on protected");
    a_strobe_in_hv: assert property (array_o.prog_stb |-> array_o.hv && array_o.program_select)
        else $error("strobe outside program");
    a_mass_locked: assert property (array_o.mass |-> protect_byte_i == 8'hFF) else $error("mass while protected");
    a_abort_standby: assert property (low_power_i && (array_o.program_select || array_o.erase || array_o.hv)
        |=> {array_o.program_select, array_o.erase, array_o.mass, array_o.hv, array_o.prog_stb} == 5'h00)
        else $error("no standby on low power");
    a_hv_off_order: assert property ($fell(array_o.hv) |-> !$past(array_o.program_select) || $past(low_power_i))
        else $error("high voltage off before deselect");
    a_ready_idle: assert property (read_ready_o |-> !array_o.hv) else $error("ready with high voltage");
endmodule

bind flp_row_prog flp_row_prog_sva #(.CNT_W(CNT_W)) i_flp_row_prog_sva (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .protect_byte_i(protect_byte_i), .test_hv_i(test_hv_i),
    .low_power_i(low_power_i), .array_o(array_o), .read_ready_o(read_ready_o));

//--- tb/tb_flp_row_prog.sv
/* self-checking bench for flp_row_prog: registers, program sequence, protection, abort
   assumes the checker file is compiled with it and binds itself */
`timescale 1ns/1ps
module tb_flp_row_prog;
    // ------------------------------------------------------------------
    // stimulus and bookkeeping
    // ------------------------------------------------------------------
    logic                 clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic                 test_hv_i = 1'b0, low_power_i = 1'b0, ack_o, read_ready_o;
    logic [7:0]           adr_i = 8'h00, protect_byte_i = 8'hFF;
    logic [31:0]          dat_i = 32'h0, dat_o, rd, seed = 32'h0000005A;
    flp_pkg::flp_mem_wr_s mem_wr_i = '0;
    flp_pkg::flp_array_s  array_o;
    int                   n_fail = 0, n_tests = 0, cycles = 0;
    logic [7:0]           cpb [7] = '{8'hFF, 8'h00, 8'hB8, 8'hB9, 8'hFE, 8'hFE, 8'hFF};
    logic [15:0]          cad [7] = '{16'hF000, 16'hEE00, 16'hEE00, 16'hEE3F, 16'hFF7F, 16'hFFBE, 16'hFFBE};

    flp_row_prog i_flp_row_prog (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .mem_wr_i(mem_wr_i),
        .protect_byte_i(protect_byte_i), .test_hv_i(test_hv_i), .low_power_i(low_power_i),
        .array_o(array_o), .read_ready_o(read_ready_o));

    initial forever #10 clk_i = ~clk_i;

    // cuts a hang short
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            n_fail++;
            complete_run();
        end
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // target may take high voltage when below the protect start or the byte is all ones; the protect byte address needs test high voltage
    function automatic logic exp_open(input logic [7:0] pb, input logic [15:0] a);
        return (a == flp_pkg::PROTECT_ADDR) ? test_hv_i : (pb == 8'hFF || a < {2'h3, pb, 6'h00});
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    // one-cycle flash write, strobe seen in either of the next two cycles
    task automatic mw(input logic [15:0] a, input logic [7:0] d, output logic s);
        @(posedge clk_i);
        mem_wr_i <= '{wr: 1'b1, addr: a, data: d};
        @(posedge clk_i);
        mem_wr_i.wr <= 1'b0;
        #1 s = array_o.prog_stb;
        @(posedge clk_i);
        #1 s = s | array_o.prog_stb;
    endtask
    task automatic run_prog(input logic [7:0] pb, input logic [15:0] a, input logic lp);
        logic ok;
        logic s;
        logic [31:0] r;
        logic [15:0] b;
        r = rnd();
        b = {a[15:5], r[4:0]};
        @(posedge clk_i);
        ok = exp_open(pb, a);
        protect_byte_i <= pb;
        wb(1'b1, flp_pkg::OFS_CTRL, 32'h1);
        wb(1'b0, flp_pkg::OFS_PROTECT, 32'h0);
        check(rd, {24'h0, pb});
        mw(a, r[15:8], s);
        wt(510);
        wb(1'b1, flp_pkg::OFS_CTRL, 32'h9);
        check(32'(array_o.hv), 32'(ok));
        if (!ok) begin
            wb(1'b0, flp_pkg::OFS_STATUS, 32'h0);
            check(32'(rd[4]), 32'h1);
            wb(1'b1, flp_pkg::OFS_STATUS, 32'h30);
            wb(1'b1, flp_pkg::OFS_CTRL, 32'h0);
        end else begin
            wt(260);
            mw(b, r[23:16], s);
            check(32'(s), 32'h1);
            check(32'({array_o.addr, array_o.data}), 32'({b, r[23:16]}));
            if (lp) begin
                @(posedge clk_i);
                low_power_i <= 1'b1;
                @(posedge clk_i);
                low_power_i <= 1'b0;
                #1 check(32'({array_o.program_select, array_o.hv}), 32'h0);
            end else begin
                wt(1510);
                mw(b ^ 16'h0020, r[23:16], s);
                check(32'(s), 32'h0);
                wb(1'b0, flp_pkg::OFS_STATUS, 32'h0);
                check(32'(rd[5]), 32'h1);
                wb(1'b1, flp_pkg::OFS_STATUS, 32'h30);
                wb(1'b1, flp_pkg::OFS_CTRL, 32'h8);
                wt(260);
                wb(1'b1, flp_pkg::OFS_CTRL, 32'h0);
                wt(60);
            end
        end
        check(32'(read_ready_o), 32'h1);
    endtask
    task automatic complete_run();
        $display("mismatches %0d in %0d comparisons", n_fail, n_tests);
        if (n_fail == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] r;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1 check(32'(array_o), 32'h0);
        wb(1'b0, flp_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h40);
        wb(1'b1, flp_pkg::OFS_PROTECT, 32'h12);
        wb(1'b0, flp_pkg::OFS_PROTECT, 32'h0);
        check(rd, 32'hFF);
        wb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        wb(1'b1, flp_pkg::OFS_CTRL, 32'h8);
        check(32'(array_o.hv), 32'h0);
        wb(1'b1, flp_pkg::OFS_CTRL, 32'h3);
        check(32'({array_o.program_select, array_o.erase}), 32'h0);
        wb(1'b1, flp_pkg::OFS_CTRL, 32'h6);
        check(32'({array_o.erase, array_o.mass}), 32'h3);
        wb(1'b1, flp_pkg::OFS_CTRL, 32'h0);
        protect_byte_i <= 8'h00;
        wb(1'b1, flp_pkg::OFS_CTRL, 32'h6);
        check(32'(array_o.mass), 32'h0);
        wb(1'b1, flp_pkg::OFS_CTRL, 32'h0);
        wb(1'b1, flp_pkg::OFS_STATUS, 32'h30);
        for (int i = 0; i < 7; i++)
            run_prog(cpb[i], cad[i], 1'b0);
        test_hv_i <= 1'b1;
        run_prog(8'hFF, 16'hFFBE, 1'b0);
        test_hv_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            r = rnd();
            run_prog(r[0] ? 8'hFF : r[31:24], 16'hEE00 + 16'(r[19:8]), 1'b0);
        end
        run_prog(8'hFF, 16'hF420, 1'b1);
        low_power_i <= 1'b1;
        wb(1'b0, flp_pkg::OFS_STATUS, 32'h0);
        check(rd, 32'h40);
        complete_run();
    end
endmodule
